/* File: dv/bitop_core_test.sv */
// Purpose: self-checking bench for the bit-operation and call execution core
// Assumes: bench drives all ports 1 ns after the rising edge
// Notes:   expected pc, acc and stack pointer are tracked by the bench
`timescale 1ns/1ps
`default_nettype none

module bitop_core_test;
    logic                         mclk = 1'b0;
    logic                         rst_n = 1'b0;
    bitop_core_pkg::instr_t       instr = '0;
    logic [7:0]                   tablePtr = 8'h00;
    bitop_core_pkg::reg_write_t   regWrite = '0;
    logic [6:0]                   viewAddr = 7'h00;
    bitop_core_pkg::core_status_t status;
    logic [7:0]                   viewData;
    logic [2:0]                   stackPtr;
    logic [10:0]                  stackTop;
    logic [10:0]                  ep = 11'h000;
    logic [2:0]                   esp = 3'h0;
    int                           n_fail = 0;
    int                           cmp_count = 0;
    int                           cyc = 0;

    bitop_core #(.STACK_DEPTH(8)) bitop_core_i (.mclk(mclk), .rst_n(rst_n), .instr(instr),
        .table_high_pointer(tablePtr), .regWrite(regWrite), .viewAddr(viewAddr),
        .status(status), .viewData(viewData), .stackPtr(stackPtr), .stackTop(stackTop));

    // clock and hang guard
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            results();
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask : chk

    // offer one instruction for one edge, outputs settled on return
    task issue(input bitop_core_pkg::op_t op, input logic [7:0] imm, input logic [6:0] a,
               input logic [2:0] b);
        instr = {1'b1, op, imm, a, b};
        @(posedge mclk);
        #1;
    endtask : issue

    // seed a data register through the side port, then read it back
    task poke(input logic [6:0] a, input logic [7:0] d);
        regWrite = {1'b1, a, d};
        viewAddr = a;
        instr.valid = 1'b0; // no instruction executes during the seed edge
        @(posedge mclk);
        #1;
        regWrite.en = 1'b0;
    endtask : poke

    task t_and;
        issue(bitop_core_pkg::OP_LOAD_ACC, 8'h5A, 7'h00, 3'h0);
        issue(bitop_core_pkg::OP_AND_IMM, 8'hAF, 7'h00, 3'h0);
        ep = ep + 11'h002;
        chk(status.acc, 8'h0A, "and acc");
        chk(status.zero, 1'b0, "and zero");
        chk(status.pc, ep, "and pc");
        issue(bitop_core_pkg::OP_AND_IMM, 8'hA5, 7'h00, 3'h0);
        ep = ep + 11'h001;
        chk({status.acc, status.zero, status.busy}, {8'h00, 2'b10}, "and z");
        $display("test and done");
    endtask : t_and

    task t_bitset;
        poke(7'h7F, 8'h5A);
        issue(bitop_core_pkg::OP_BIT_SET, 8'h00, 7'h7F, 3'h2);
        issue(bitop_core_pkg::OP_NOP, 8'h00, 7'h00, 3'h0);
        ep = ep + 11'h002;
        chk(viewData, 8'h5E, "bit set");
        chk(status.zero, 1'b1, "bit set flag");
        poke(7'h00, 8'h00);
        issue(bitop_core_pkg::OP_BIT_SET, 8'h00, 7'h00, 3'h7);
        issue(bitop_core_pkg::OP_NOP, 8'h00, 7'h00, 3'h0);
        ep = ep + 11'h002;
        chk(viewData, 8'h80, "bit set 7");
        chk(status.pc, ep, "bit set pc");
        $display("test bitset done");
    endtask : t_bitset

    task t_skip;
        logic       skp;
        logic [7:0] eacc;
        poke(7'h10, 8'h5A);
        issue(bitop_core_pkg::OP_LOAD_ACC, 8'h11, 7'h00, 3'h0);
        ep = ep + 11'h001;
        eacc = 8'h11;
        for (int k = 0; k < 4; k++) begin
            skp = (k == 0) || (k == 3);
            issue(k < 2 ? bitop_core_pkg::OP_TEST_CLR : bitop_core_pkg::OP_TEST_SET,
                  8'h00, 7'h10, k[0] ? 3'h3 : 3'h2);
            ep = ep + 11'h001;
            chk(status.busy, skp, "skip busy");
            chk(status.pc, ep, "test pc");
            issue(bitop_core_pkg::OP_LOAD_ACC, 8'h20 + 8'(k), 7'h00, 3'h0);
            ep = ep + 11'h001;
            if (!skp) eacc = 8'h20 + 8'(k);
            chk(status.acc, eacc, "skipped slot");
            chk({status.pc, status.busy}, {ep, 1'b0}, "after test");
        end
        $display("test skip done");
    endtask : t_skip

    task t_call;
        issue(bitop_core_pkg::OP_LOAD_ACC, 8'h34, 7'h00, 3'h0);
        ep = ep + 11'h001;
        tablePtr = 8'hFA;
        issue(bitop_core_pkg::OP_CALL_IND, 8'h00, 7'h00, 3'h0);
        esp = esp + 3'h1;
        chk({status.pc, status.busy}, {11'h234, 1'b1}, "call pc");
        chk(stackTop, ep + 11'h001, "call push");
        chk(stackPtr, esp, "call sp");
        issue(bitop_core_pkg::OP_LOAD_ACC, 8'h99, 7'h00, 3'h0);
        chk({status.acc, status.pc, status.busy}, {8'h34, 11'h234, 1'b0}, "flush");
        tablePtr = 8'h05;
        issue(bitop_core_pkg::OP_CALL_IND, 8'h00, 7'h00, 3'h0);
        esp = esp + 3'h1;
        chk(status.pc, 11'h534, "call2 pc");
        chk({stackTop, stackPtr}, {11'h235, esp}, "call2 push");
        issue(bitop_core_pkg::OP_NOP, 8'h00, 7'h00, 3'h0);
        ep = 11'h534; // flush slot holds the target, offered nop ignored
        $display("test call done");
    endtask : t_call

    task t_clr;
        issue(bitop_core_pkg::OP_LOAD_ACC, 8'h55, 7'h00, 3'h0);
        issue(bitop_core_pkg::OP_AND_IMM, 8'hFF, 7'h00, 3'h0);
        chk(status.zero, 1'b0, "pre clr");
        issue(bitop_core_pkg::OP_CLR_ACC, 8'h00, 7'h00, 3'h0);
        ep = ep + 11'h003;
        chk({status.acc, status.zero, status.pc}, {8'h00, 1'b1, ep}, "clr");
        $display("test clr done");
    endtask : t_clr

    task results;
        $display("compares %0d fails %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results

    // reset, then each scenario in turn
    initial begin
        repeat (3) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        chk({status.acc, status.zero, status.pc, stackPtr}, '0, "reset");
        t_and();
        t_bitset();
        t_skip();
        t_call();
        t_clr();
        results();
    end
endmodule : bitop_core_test

`default_nettype wire

/* File: verilog/bitop_core.sv */
// Purpose: executes and-immediate, bit set, bit tests with skip, indirect call, clear acc
// Assumes: instructions arrive decoded, one per cycle, synchronous to mclk
// Notes:   second cycle of a skip or call ignores the offered instruction
// How it works
// - and-immediate ands acc with 8-bit immediate, updates only zero, one cycle
// - bit set forces bit 0..7 of register 0..127 to one, flags untouched
// - skip-if-clear discards next instruction as a nop when bit is zero
// - skip-if-set discards next instruction as a nop when bit is one
// - indirect call pushes pc plus one onto stack, takes two cycles
// - call target is pointer bits 2..0 above acc bits 7..0
// - clear-acc writes zero to acc and sets zero flag, one cycle
// - bit operands address the register page spanning 0 to 127
`timescale 1ns/1ps
`default_nettype none
`include "bitop_core_cfg.svh"

module bitop_core #(
    parameter int STACK_DEPTH = `STACK_DEPTH_DEF
) (
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    input  wire bitop_core_pkg::instr_t        instr,
    input  wire logic [7:0]                    table_high_pointer,
    input  wire bitop_core_pkg::reg_write_t    regWrite,
    input  wire logic [6:0]                    viewAddr,
    output var  bitop_core_pkg::core_status_t  status,
    output logic [7:0]                         viewData,
    output logic [$clog2(STACK_DEPTH)-1:0]     stackPtr,
    output logic [10:0]                        stackTop
);

    localparam int SPW = $clog2(STACK_DEPTH);

    // refuse stack depths the pointer cannot wrap cleanly
    if (STACK_DEPTH < 2 || (1 << SPW) != STACK_DEPTH) begin : g_bad_depth
        $error("STACK_DEPTH must be a power of two, at least 2");
    end

    // read one bit of a register byte
    function automatic logic pickBit(input logic [7:0] data, input logic [2:0] sel);
        pickBit = data[sel];
    endfunction : pickBit

    bitop_core_pkg::state_t state_q, state_d;
    logic [7:0]  acc_q, acc_d;
    logic        zero_q, zero_d;
    logic [10:0] pc_q, pc_d;
    logic [SPW-1:0] sp_q, sp_d;
    logic [7:0]  regs_q [`REG_COUNT];
    logic [7:0]  regs_d [`REG_COUNT];
    logic [10:0] stack_q [STACK_DEPTH];
    logic [10:0] stack_d [STACK_DEPTH];
    logic [7:0]  view_q, view_d;
    logic [10:0] top_q, top_d;
    logic        busy_q, busy_d;
    logic        opBit;
    logic        doExec;

    assign opBit  = pickBit(regs_q[instr.addr], instr.bitSel);
    assign doExec = (state_q == bitop_core_pkg::ST_EXEC) && instr.valid;

    // next-state of the execution engine
    always_comb begin
        state_d = bitop_core_pkg::ST_EXEC;
        acc_d   = acc_q;
        zero_d  = zero_q;
        pc_d    = pc_q;
        sp_d    = sp_q;
        regs_d  = regs_q;
        stack_d = stack_q;
        if (regWrite.en) begin
            regs_d[regWrite.addr] = regWrite.data; // side port, loses to bit set
        end
        if (state_q == bitop_core_pkg::ST_SKIP_NOP) begin
            pc_d = pc_q + `PC_STEP; // discarded slot executes as nop
        end else if (doExec) begin
            pc_d = pc_q + `PC_STEP;
            case (instr.op)
                bitop_core_pkg::OP_LOAD_ACC: begin
                    acc_d = instr.imm;
                end
                bitop_core_pkg::OP_AND_IMM: begin
                    acc_d  = acc_q & instr.imm;
                    zero_d = ((acc_q & instr.imm) == `ACC_CLEARED);
                end
                bitop_core_pkg::OP_BIT_SET: begin
                    // rebuild from the old byte, so a same-edge side write is lost
                    regs_d[instr.addr] = regs_q[instr.addr];
                    regs_d[instr.addr][instr.bitSel] = 1'b1;
                end
                bitop_core_pkg::OP_TEST_CLR: begin
                    if (!opBit) begin
                        state_d = bitop_core_pkg::ST_SKIP_NOP;
                    end
                end
                bitop_core_pkg::OP_TEST_SET: begin
                    if (opBit) begin
                        state_d = bitop_core_pkg::ST_SKIP_NOP;
                    end
                end
                bitop_core_pkg::OP_CALL_IND: begin
                    stack_d[sp_q] = pc_q + `PC_STEP;
                    sp_d  = sp_q + SPW'(`SP_STEP);
                    pc_d  = {table_high_pointer[`PTR_PC_BITS-1:0], acc_q};
                    state_d = bitop_core_pkg::ST_CALL_FLUSH;
                end
                bitop_core_pkg::OP_CLR_ACC: begin
                    acc_d  = `ACC_CLEARED;
                    zero_d = 1'b1;
                end
                default: begin
                end
            endcase
        end else if (state_q == bitop_core_pkg::ST_EXEC) begin
            pc_d = pc_q; // no instruction offered
        end
    end

    // observation taps
    always_comb begin
        view_d = regs_d[viewAddr];
        top_d  = stack_d[sp_d - SPW'(`SP_STEP)];
        busy_d = (state_d != bitop_core_pkg::ST_EXEC); // registered so busy leaves a flop
    end

    // state registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= bitop_core_pkg::ST_EXEC;
            acc_q   <= `ACC_RESET;
            zero_q  <= `ZERO_RESET;
            pc_q    <= `PC_RESET;
            sp_q    <= '0;
            view_q  <= `REG_RESET;
            top_q   <= `PC_RESET;
            busy_q  <= `BUSY_RESET;
            for (int i = 0; i < `REG_COUNT; i++) begin
                regs_q[i] <= `REG_RESET;
            end
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_q[i] <= `PC_RESET;
            end
        end else begin
            state_q <= state_d;
            acc_q   <= acc_d;
            zero_q  <= zero_d;
            pc_q    <= pc_d;
            sp_q    <= sp_d;
            view_q  <= view_d;
            top_q   <= top_d;
            busy_q  <= busy_d;
            regs_q  <= regs_d;
            stack_q <= stack_d;
        end
    end

    // outputs straight from flops
    assign status = '{
        acc:  acc_q,
        zero: zero_q,
        pc:   pc_q,
        busy: busy_q
    };
    assign viewData    = view_q;
    assign stackPtr    = sp_q;
    assign stackTop    = top_q;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    wire isOp_and  = doExec && instr.op == bitop_core_pkg::OP_AND_IMM;
    wire isOp_set  = doExec && instr.op == bitop_core_pkg::OP_BIT_SET;
    wire isOp_tclr = doExec && instr.op == bitop_core_pkg::OP_TEST_CLR;
    wire isOp_tset = doExec && instr.op == bitop_core_pkg::OP_TEST_SET;
    wire isOp_call = doExec && instr.op == bitop_core_pkg::OP_CALL_IND;
    wire isOp_clr  = doExec && instr.op == bitop_core_pkg::OP_CLR_ACC;

    a_and_result: assert property (isOp_and |=>
        acc_q == ($past(acc_q) & $past(instr.imm)) && zero_q == (acc_q == `ACC_CLEARED))
        else $error("and-immediate result or zero flag wrong");
    a_and_single: assert property (isOp_and |=>
        !status.busy)
        else $error("and-immediate took more than one cycle");
    a_set_bit: assert property (isOp_set && !regWrite.en |=>
        regs_q[$past(instr.addr)] ==
        ($past(regs_q[instr.addr]) | (`BIT_LSB << $past(instr.bitSel))) && $stable(zero_q))
        else $error("bit set changed wrong bits or flags");
    a_skip_clear: assert property (isOp_tclr && !opBit |=>
        status.busy ##1 !status.busy && pc_q == $past(pc_q, 2) + `PC_STEP + `PC_STEP)
        else $error("skip-if-clear did not discard one slot");
    a_noskip_clear: assert property (isOp_tclr && opBit |=>
        !status.busy)
        else $error("skip-if-clear skipped on a set bit");
    a_skip_set: assert property (isOp_tset |=>
        status.busy == $past(opBit))
        else $error("skip-if-set decision wrong");
    a_call_push: assert property (isOp_call |=>
        stackTop == $past(pc_q) + `PC_STEP && status.busy ##1 !status.busy)
        else $error("call return address or length wrong");
    a_call_target: assert property (isOp_call |=>
        pc_q == {$past(table_high_pointer[`PTR_PC_BITS-1:0]), $past(acc_q)})
        else $error("call target wrong");
    a_call_sp: assert property (isOp_call |=>
        stackPtr == $past(stackPtr) + SPW'(`SP_STEP))
        else $error("stack pointer did not advance");
    a_clr_acc: assert property (isOp_clr |=>
        acc_q == `ACC_CLEARED && zero_q && !status.busy)
        else $error("clear-acc wrong");

    // flush and skipped slots leave the working state alone
    a_flush_hold: assert property (isOp_call ##1 1'b1 |=>
        pc_q == $past(pc_q) && acc_q == $past(acc_q))
        else $error("call flush cycle changed pc or acc");
    a_skip_slot: assert property ((isOp_tclr && !opBit) || (isOp_tset && opBit) |=>
        ##1 acc_q == $past(acc_q) && zero_q == $past(zero_q))
        else $error("skipped slot changed acc or zero");

    c_skip_taken: cover property (isOp_tclr && !opBit ##1 status.busy);
    c_set_pass:   cover property (isOp_tset && !opBit);
    c_set_skip:   cover property (isOp_tset && opBit);
    c_call:       cover property (isOp_call ##2 isOp_and);
    c_clr_then_and: cover property (isOp_clr ##1 isOp_and);

endmodule : bitop_core

`default_nettype wire

/* File: verilog/bitop_core_cfg.svh */
// Purpose: named constants for the bit-operation and call execution core
// Assumes: included by the core module
// Notes:   definitions only
`ifndef BITOP_CORE_CFG_SVH
`define BITOP_CORE_CFG_SVH

`define ACC_RESET      8'h00
`define PC_RESET       11'h000
`define REG_RESET      8'h00
`define ZERO_RESET     1'b0
`define ACC_CLEARED    8'h00
`define PC_STEP        11'h001
`define SP_STEP        1
`define STACK_DEPTH_DEF 8
`define PTR_PC_BITS    3
`define REG_COUNT      128
`define BIT_LSB        8'h01
`define BUSY_RESET     1'b0

`endif

/* File: verilog/bitop_core_pkg.sv */
// Purpose: types shared by the bit-operation and call execution core
// Assumes: bitop_core_cfg.svh holds the numeric constants
// Notes:   instruction and status travel as packed structs
`default_nettype none

package bitop_core_pkg;

    // executable operations, decoded upstream
    typedef enum logic [2:0] {
        OP_NOP,
        OP_LOAD_ACC,
        OP_AND_IMM,
        OP_BIT_SET,
        OP_TEST_CLR,
        OP_TEST_SET,
        OP_CALL_IND,
        OP_CLR_ACC
    } op_t;

    // execution phase
    typedef enum logic [1:0] {
        ST_EXEC,
        ST_SKIP_NOP,
        ST_CALL_FLUSH
    } state_t;

    typedef struct packed {
        logic       valid;
        op_t        op;
        logic [7:0] imm;
        logic [6:0] addr;
        logic [2:0] bitSel;
    } instr_t;

    typedef struct packed {
        logic       en;
        logic [6:0] addr;
        logic [7:0] data;
    } reg_write_t;

    typedef struct packed {
        logic [7:0]  acc;
        logic        zero;
        logic [10:0] pc;
        logic        busy;
    } core_status_t;

endpackage : bitop_core_pkg

`default_nettype wire
